// file: psc_cfg.svh
// psc_cfg.svh: constants of the pipelined sram pin control block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
// ============================================================
// ============================================================
// widths and depths
`define PSC_ADDR_W 19
`define PSC_LANES 8
`define PSC_BYTE_W 8
`define PSC_LANE_W 9
`define PSC_FIFO_DEPTH 16
// reset values
`define PSC_MODE_RST 1'b1
`define PSC_CNT_RST 2'h0
`endif

// file: psc_pkg.sv
// psc_pkg.sv: types shared by the pipelined sram pin control block
package psc_pkg;
  // ============================================================
  // access kinds
  typedef enum logic [1:0] {
    PSC_OP_NONE = 2'b00,
    PSC_OP_READ = 2'b01,
    PSC_OP_WRITE = 2'b10
  } psc_op_e;
  // ============================================================
  // burst counter
  typedef logic [1:0] psc_burst_t;
endpackage : psc_pkg

// file: psc_wbuf_if.sv
// psc_wbuf_if.sv: valid/ready carrier between the core and its write buffer
`timescale 1ns/100ps
interface psc_wbuf_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface : psc_wbuf_if

// file: psc_fifo.sv
// psc_fifo.sv: write buffer fifo with valid/ready on both sides
`timescale 1ns/100ps
module psc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill and drain sides
  psc_wbuf_if.buffer bus
);
  import psc_pkg::*;
  // depth must be a power of two so the pointers wrap by themselves
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } psc_fifo_s;
  psc_fifo_s r;
  psc_fifo_s n;
  logic push;
  logic pop;
  // ============================================================
  // flags and head
  assign bus.in_ready = (r.cnt != (PW+1)'(DEPTH));
  assign bus.out_valid = (r.cnt != '0);
  assign bus.out_data = r.mem[r.rp];
  // ============================================================
  // next state
  always_comb
  begin
    n = r;
    push = bus.in_valid & bus.in_ready;
    pop = bus.out_valid & bus.out_ready;
    if (push)
    begin
      n.mem[r.wp] = bus.in_data;
      n.wp = r.wp + 1'b1;
    end
    if (pop)
    begin
      n.rp = r.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: n.cnt = r.cnt + 1'b1;
      2'b01: n.cnt = r.cnt - 1'b1;
      default: n.cnt = r.cnt;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end
endmodule : psc_fifo

// file: psc_top.sv
// psc_top.sv: control, data path and array of the pipelined burst sram
`timescale 1ns/100ps
`include "psc_cfg.svh"
module psc_top #(
  parameter int ADDR_W = `PSC_ADDR_W,
  parameter int LANES = `PSC_LANES,
  parameter int FIFO_DEPTH = `PSC_FIFO_DEPTH
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // address and control
  input wire logic [ADDR_W-1:0] addr,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic chip_select_low_a,
  input wire logic chip_select_high,
  input wire logic chip_select_low_b,
  input wire logic write_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic out_enable_n,
  input wire logic burst_order_strap,
  // data lanes
  input wire logic [`PSC_BYTE_W*LANES-1:0] data_in,
  output logic [`PSC_BYTE_W*LANES-1:0] data_out,
  output logic [`PSC_BYTE_W*LANES-1:0] data_oe,
  // parity lanes
  input wire logic [LANES-1:0] parity_lines_in,
  output logic [LANES-1:0] parity_lines_out,
  output logic [LANES-1:0] parity_lines_oe
);
  import psc_pkg::*;

  // ============================================================
  // geometry
  localparam int BW = `PSC_BYTE_W;
  localparam int LW = `PSC_LANE_W;
  localparam int DW = BW * LANES;
  localparam int WW = LW * LANES;
  localparam int WORDS = 2 ** ADDR_W;
  localparam int EW = ADDR_W + LANES + WW;

  // ============================================================
  // state
  // the array lives in flip-flops; shrink ADDR_W for simulation
  typedef struct packed {
    logic [WORDS-1:0][WW-1:0] mem;
    logic mode;
    logic mode_set;
    psc_op_e op;
    logic [ADDR_W-1:0] base;
    psc_burst_t cnt;
    psc_op_e ph_op;
    logic [ADDR_W-1:0] ph_addr;
    logic [LANES-1:0] ph_bw_n;
    logic [DW-1:0] dout;
    logic [DW-1:0] doe;
    logic [LANES-1:0] pout;
    logic [LANES-1:0] poe;
  } psc_core_s;

  psc_core_s r;
  psc_core_s n;

  // ============================================================
  // helpers

  // one array word: per lane {parity, byte}
  function automatic logic [WW-1:0] pack_word(
    input logic [DW-1:0] d,
    input logic [LANES-1:0] p
  );
    logic [WW-1:0] w;
    w = '0;
    for (int l = 0; l < LANES; l++)
    begin
      w[l*LW +: LW] = {p[l], d[l*BW +: BW]};
    end
    return w;
  endfunction : pack_word

  // lane merge; a lane whose select is low takes the new value
  function automatic logic [WW-1:0] merge_word(
    input logic [WW-1:0] old_w,
    input logic [WW-1:0] new_w,
    input logic [LANES-1:0] sel_n
  );
    logic [WW-1:0] w;
    w = old_w;
    for (int l = 0; l < LANES; l++)
    begin
      if (!sel_n[l])
      begin
        w[l*LW +: LW] = new_w[l*LW +: LW];
      end
    end
    return w;
  endfunction : merge_word

  // burst address from base and beat count
  function automatic logic [ADDR_W-1:0] burst_addr(
    input logic [ADDR_W-1:0] base,
    input psc_burst_t cnt,
    input logic interleave
  );
    logic [ADDR_W-1:0] a;
    a = base;
    if (interleave)
    begin
      a[1:0] = base[1:0] ^ cnt;
    end
    else
    begin
      a[1:0] = base[1:0] + cnt;
    end
    return a;
  endfunction : burst_addr

  // ============================================================
  // write buffer
  psc_wbuf_if #(.W(EW)) wb ();

  psc_fifo #(
    .W(EW),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk(clk),
    .rst_n(rst_n),
    .bus(wb)
  );

  logic [ADDR_W-1:0] hd_addr;
  logic [LANES-1:0] hd_sel_n;
  logic [WW-1:0] hd_word;
  assign {hd_addr, hd_sel_n, hd_word} = wb.out_data;

  // ============================================================
  // next state
  logic qual;
  logic sel;
  logic interleave;
  logic [ADDR_W-1:0] next_addr;
  logic [WW-1:0] rd_word;
  logic [WW-1:0] wr_word;

  always_comb
  begin
    n = r;
    rd_word = '0;
    wr_word = '0;
    next_addr = r.base;
    // edge counts only while qualify is low
    // a full buffer also holds the edge, so no write data is lost
    qual = ~clock_qualify_n & wb.in_ready;
    sel = ~chip_select_low_a & chip_select_high & ~chip_select_low_b;
    interleave = r.mode_set ? r.mode : burst_order_strap;
    wb.in_valid = 1'b0;
    wb.in_data = '0;
    // draining stalls with the clock, but writes enter only on qualified edges, so the buffer holds one entry at most
    wb.out_ready = ~clock_qualify_n;

    // strap is caught once after reset; a floating pin reads high
    if (!r.mode_set)
    begin
      n.mode = burst_order_strap;
      n.mode_set = 1'b1;
    end

    // array update from the buffer head
    if (wb.out_valid && wb.out_ready)
    begin
      n.mem[hd_addr] = merge_word(r.mem[hd_addr], hd_word, hd_sel_n);
    end

    if (qual)
    begin
      // data phase of the access taken at the previous edge
      case (r.ph_op)
        PSC_OP_WRITE:
        begin
          // write data captured into the buffer register
          // parity lanes travel with their byte
          wr_word = pack_word(data_in, parity_lines_in);
          wb.in_valid = 1'b1;
          wb.in_data = {r.ph_addr, r.ph_bw_n, wr_word};
          // no drive during the write data phase
          n.doe = '0;
          n.poe = '0;
        end
        PSC_OP_READ:
        begin
          // word addressed at the preceding edge
          rd_word = r.mem[r.ph_addr];
          // pending write to the same word is forwarded only from the buffer head
          if (wb.out_valid && (hd_addr == r.ph_addr))
          begin
            rd_word = merge_word(rd_word, hd_word, hd_sel_n);
          end
          for (int l = 0; l < LANES; l++)
          begin
            n.dout[l*BW +: BW] = rd_word[l*LW +: BW];
            n.pout[l] = rd_word[l*LW + BW];
          end
          n.doe = {DW{~out_enable_n}};
          n.poe = {LANES{~out_enable_n}};
        end
        default:
        begin
          // deselected or first clock after deselect
          n.doe = '0;
          n.poe = '0;
        end
      endcase

      // address phase
      if (advance_or_load)
      begin
        // step the burst counter and repeat the access kind
        if (r.op != PSC_OP_NONE)
        begin
          n.cnt = r.cnt + 1'b1;
          next_addr = burst_addr(r.base, n.cnt, interleave);
          n.ph_op = r.op;
          n.ph_addr = next_addr;
          n.ph_bw_n = byte_lane_select_n;
        end
        else
        begin
          n.ph_op = PSC_OP_NONE;
        end
      end
      else if (sel)
      begin
        n.base = addr;
        n.cnt = `PSC_CNT_RST;
        n.ph_addr = addr;
        // write strobe qualifies the byte selects
        if (!write_n)
        begin
          n.op = PSC_OP_WRITE;
          n.ph_op = PSC_OP_WRITE;
          n.ph_bw_n = byte_lane_select_n;
        end
        else
        begin
          n.op = PSC_OP_READ;
          n.ph_op = PSC_OP_READ;
          n.ph_bw_n = '1;
        end
      end
      else
      begin
        n.op = PSC_OP_NONE;
        n.ph_op = PSC_OP_NONE;
      end
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.mode <= `PSC_MODE_RST;
    end
    else
    begin
      r <= n;
    end
  end

  // ============================================================
  // pins
  assign data_out = r.dout;
  assign data_oe = r.doe;
  assign parity_lines_out = r.pout;
  assign parity_lines_oe = r.poe;

endmodule : psc_top

// file: psc_top_props.sv
// psc_top_props.sv: port-level checks of the pipelined sram pin control block
`timescale 1ns/100ps
`include "psc_cfg.svh"
module psc_top_props #(
  parameter int ADDR_W = `PSC_ADDR_W,
  parameter int LANES = `PSC_LANES
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic [ADDR_W-1:0] addr,
  input wire logic advance_or_load,
  input wire logic clock_qualify_n,
  input wire logic chip_select_low_a,
  input wire logic chip_select_high,
  input wire logic chip_select_low_b,
  input wire logic write_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic out_enable_n,
  // data and parity
  input wire logic [`PSC_BYTE_W*LANES-1:0] data_in,
  input wire logic [`PSC_BYTE_W*LANES-1:0] data_out,
  input wire logic [`PSC_BYTE_W*LANES-1:0] data_oe,
  input wire logic [LANES-1:0] parity_lines_in,
  input wire logic [LANES-1:0] parity_lines_out,
  input wire logic [LANES-1:0] parity_lines_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic sel;
  assign sel = !chip_select_low_a && chip_select_high && !chip_select_low_b;
  // ============================================================
  // steps of an access
  sequence s_q; !clock_qualify_n; endsequence
  sequence s_rd; s_q ##0 !advance_or_load && sel && write_n; endsequence
  sequence s_wr; s_q ##0 !advance_or_load && sel && !write_n; endsequence
  sequence s_ds; s_q ##0 !advance_or_load && !sel; endsequence
  // ============================================================
  // checks
  a_lane_oe_equal: assert property (
    data_oe == {`PSC_BYTE_W*LANES{parity_lines_oe[0]}} && parity_lines_oe == {LANES{parity_lines_oe[0]}})
    else $error("lane enables differ");
  a_suspend_hold: assert property (
    clock_qualify_n |=> $stable(data_out) && $stable(data_oe)) else $error("suspended cycle changed outputs");
  a_oe_mask: assert property (s_q ##0 out_enable_n |=> data_oe == '0)
    else $error("driving with output enable off");
  a_desel_float: assert property (s_ds ##1 s_q |=> data_oe == '0)
    else $error("driving after deselect");
  a_write_float: assert property (s_wr ##1 s_q |=> data_oe == '0)
    else $error("driving in write data phase");
  a_read_drive: assert property (s_rd ##1 (s_q ##0 !out_enable_n) |=> &data_oe)
    else $error("read not driven");
  a_wr_rd_fwd: assert property (
    (s_wr ##0 byte_lane_select_n == '0) ##1 (s_rd ##0 addr == $past(addr)) ##1 (s_q ##0 !out_enable_n)
    |=> data_out == $past(data_in, 2) && parity_lines_out == $past(parity_lines_in, 2))
    else $error("written word not read back");
  a_reset_quiet: assert property ($rose(rst_n) |-> data_oe == '0)
    else $error("driving out of reset");
endmodule : psc_top_props

// file: psc_ctl_model.sv
// psc_ctl_model.sv: memory controller model driving the block's pins
`timescale 1ns/100ps
`include "psc_cfg.svh"
module psc_ctl_model #(
  parameter int ADDR_W = 6,
  parameter int LANES = 8
)(
  // clock
  input wire logic clk,
  // pins toward the block
  output logic [ADDR_W-1:0] addr,
  output logic advance_or_load,
  output logic clock_qualify_n,
  output logic chip_select_low_a,
  output logic chip_select_high,
  output logic chip_select_low_b,
  output logic write_n,
  output logic [LANES-1:0] byte_lane_select_n,
  output logic out_enable_n,
  output logic [`PSC_BYTE_W*LANES-1:0] data_in,
  output logic [LANES-1:0] parity_lines_in
);
  int desel_r;
  logic was_desel_r;
  initial
  begin
    {addr, advance_or_load, write_n, byte_lane_select_n, data_in, parity_lines_in} = '0;
    {clock_qualify_n, out_enable_n} = '0;
    {chip_select_low_a, chip_select_high, chip_select_low_b} = 3'b101;
    desel_r = 0;
    was_desel_r = 1;
  end
  // one cycle: kind 0 deselect, 1 read, 2 write
  task automatic cyc(input int kind, input logic adv, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
                     input logic [`PSC_LANE_W*LANES-1:0] wd, input logic qn, input logic oen);
    @(negedge clk);
    clock_qualify_n = qn;
    out_enable_n = oen;
    addr = a;
    byte_lane_select_n = bw;
    // lines never rest on the last value, the block must not rely on it
    {parity_lines_in, data_in} = wd;
    advance_or_load = adv && !was_desel_r && kind != 0;
    write_n = kind != 2;
    // each select takes a turn at deselecting
    chip_select_low_a = kind == 0 && desel_r == 0;
    chip_select_high = !(kind == 0 && desel_r == 1);
    chip_select_low_b = kind == 0 && desel_r == 2;
    if (!qn)
    begin
      was_desel_r = kind == 0;
      if (kind == 0) desel_r = (desel_r + 1) % 3;
    end
  endtask : cyc
endmodule : psc_ctl_model

// file: psc_tb_top.sv
// psc_tb_top.sv: self-checking bench of the pipelined sram pin control block
`timescale 1ns/100ps
`include "psc_cfg.svh"
module psc_tb_top;
  localparam int ADDR_W = 6;
  localparam int LANES = `PSC_LANES;
  localparam int DW = `PSC_BYTE_W*LANES;
  logic clk, rst_n, burst_order_strap, advance_or_load, clock_qualify_n, write_n, out_enable_n;
  logic chip_select_low_a, chip_select_high, chip_select_low_b, exp_oe;
  logic [ADDR_W-1:0] addr, base, ph_addr;
  logic [LANES-1:0] byte_lane_select_n, parity_lines_in, parity_lines_out, parity_lines_oe, ph_bw;
  logic [DW-1:0] data_in, data_out, data_oe;
  logic [DW+LANES-1:0] mem [2**ADDR_W];
  logic [DW+LANES-1:0] exp_d;
  logic [31:0] seed, r;
  int fails, tests_run, cycles, ph_kind, last_kind, cnt, mode, caught;
  psc_top #(.ADDR_W(ADDR_W)) dut_u (.*);
  psc_ctl_model #(.ADDR_W(ADDR_W), .LANES(LANES)) ctl_u (.*);
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic chk(input string what, input logic [DW+LANES-1:0] seen, input logic [DW+LANES-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic op(input int kind, input logic adv, input logic [5:0] a, input logic [7:0] bw, input logic qn,
                    input logic oen);
    logic [95:0] w;
    w = {rnd(), rnd(), rnd()};
    ctl_u.cyc(kind, adv, a, bw, w[DW+LANES-1:0], qn, oen);
  endtask : op
  // ============================================================
  // reference model, one step per qualified edge
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      foreach (mem[i]) mem[i] = '0;
      {ph_kind, last_kind, caught, exp_oe} = '0;
    end
    else
    begin
      if (!caught) mode = burst_order_strap;
      caught = 1;
      if (!clock_qualify_n)
      begin
        exp_oe = ph_kind == 1 && !out_enable_n;
        exp_d = mem[ph_addr];
        // byte select gates its data and parity lane
        for (int l = 0; l < LANES; l++)
          if (ph_kind == 2 && !ph_bw[l])
            {mem[ph_addr][DW+l], mem[ph_addr][8*l+:8]} = {parity_lines_in[l], data_in[8*l+:8]};
        if (!advance_or_load)
        begin
          last_kind = !(!chip_select_low_a && chip_select_high && !chip_select_low_b) ? 0 : write_n ? 1 : 2;
          base = addr;
          cnt = 0;
        end
        else if (last_kind != 0) cnt++;
        ph_kind = last_kind;
        ph_bw = byte_lane_select_n;
        ph_addr = mode ? base ^ cnt[1:0] : {base[ADDR_W-1:2], base[1:0] + cnt[1:0]};
      end
    end
  always @(negedge clk)
    if (rst_n && caught)
    begin
      chk("drive enables", {parity_lines_oe, data_oe}, {DW+LANES{exp_oe}});
      if (exp_oe) chk("read data", {parity_lines_out, data_out}, exp_d);
    end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      summarize();
    end
  end
  // ============================================================
  // main sequence, once per burst order
  initial
  begin
    {seed, fails, tests_run, cycles} = {32'hbd932c44, 96'h0};
    for (int m = 1; m >= 0; m--)
    begin
      rst_n = 0;
      burst_order_strap = m[0];
      repeat (2) @(negedge clk);
      rst_n = 1;
      op(2, 0, 6'h05, 8'h00, 0, 0);
      op(1, 0, 6'h05, 8'hff, 0, 0);
      op(2, 0, 6'h06, 8'h5a, 0, 0);
      op(2, 1, 6'h00, 8'ha5, 0, 0);
      op(1, 0, 6'h06, 8'hff, 1, 0);
      op(1, 0, 6'h06, 8'hff, 0, 0);
      op(1, 1, 6'h00, 8'hff, 0, 1);
      repeat (3) op(0, 0, 6'h00, 8'hff, 0, 0);
      op(1, 1, 6'h07, 8'hff, 0, 0);
      for (int i = 0; i < 300; i++)
      begin
        r = rnd();
        op(r[1:0] == 3 ? 1 : int'(r[1:0]), r[2], r[8:3], r[16:9], r[19:17] == 0, r[22:20] == 0);
      end
      repeat (3) op(1, 1, 6'h00, 8'hff, 0, 0);
    end
    summarize();
  end
endmodule : psc_tb_top
bind psc_top psc_top_props #(.ADDR_W(ADDR_W), .LANES(LANES)) props_u (.*);
